// file: hdl/lg_tx_irq_gate.sv
// transmit driver enables and block interrupt gate register bank
`timescale 1ns/1ps
module lg_tx_irq_gate
    import lg_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic tx_drive_pin_ch0_in,
    input wire logic tx_drive_pin_ch1_in,
    input wire logic tx_pos_ch0_in,
    input wire logic tx_neg_ch0_in,
    input wire logic tx_pos_ch1_in,
    input wire logic tx_neg_ch1_in,
    output logic line_out_pos_ch0_out,
    output logic line_out_pos_ch0_oe_out,
    output logic line_out_neg_ch0_out,
    output logic line_out_neg_ch0_oe_out,
    output logic line_out_pos_ch1_out,
    output logic line_out_pos_ch1_oe_out,
    output logic line_out_neg_ch1_out,
    output logic line_out_neg_ch1_oe_out,
    input wire logic [11:0] irq_src_pending_in,
    input wire logic [11:0] irq_src_enable_in,
    output logic irq_req_out
);
    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    lg_reg_if bus ();
    lg_serial_port u_port (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .cs_n_in(cs_n_in),
        .sclk_in(sclk_in),
        .sdi_in(sdi_in),
        .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out),
        .bus(bus)
    );
    function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
        hit = (a == off);
    endfunction
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [1:0] tx_on;
    logic [1:0] next_tx_on;
    logic [2:0] irq_en;
    logic [2:0] next_irq_en;
    always_comb begin
        next_tx_on = tx_on;
        next_irq_en = irq_en;
        if (bus.wr_stb && hit(bus.addr, LG_OFF_LINE_SECTION_POWER)) begin
            next_tx_on = bus.wdata[1:0];
        end
        if (bus.wr_stb && hit(bus.addr, LG_OFF_BLOCK_IRQ_ENABLE)) begin
            next_irq_en = bus.wdata[2:0];
        end
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_on <= LG_RST_TX_ON;
            irq_en <= LG_RST_IRQ_EN;
        end else begin
            tx_on <= next_tx_on;
            irq_en <= next_irq_en;
        end
    end
    always_comb begin
        bus.rdata = 8'h00;
        if (hit(bus.addr, LG_OFF_LINE_SECTION_POWER)) begin
            bus.rdata = {6'h00, tx_on};
        end else if (hit(bus.addr, LG_OFF_BLOCK_IRQ_ENABLE)) begin
            bus.rdata = {5'h00, irq_en};
        end
    end
    // ------------------------------------------------------------
    // line drivers
    // ------------------------------------------------------------
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
        end else begin
            pin_s1 <= {tx_drive_pin_ch1_in, tx_drive_pin_ch0_in};
            pin_s2 <= pin_s1;
        end
    end
    logic [1:0] drv_en;
    logic [1:0] tx_pos;
    logic [1:0] tx_neg;
    logic [1:0] line_pos;
    logic [1:0] next_line_pos;
    logic [1:0] line_neg;
    logic [1:0] next_line_neg;
    logic [1:0] line_oe;
    assign tx_pos = {tx_pos_ch1_in, tx_pos_ch0_in};
    assign tx_neg = {tx_neg_ch1_in, tx_neg_ch0_in};
    assign drv_en = tx_on & pin_s2;
    always_comb begin
        next_line_pos = tx_pos & drv_en;
        next_line_neg = tx_neg & drv_en;
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            line_pos <= 2'h0;
            line_neg <= 2'h0;
            line_oe <= 2'h0;
        end else begin
            line_pos <= next_line_pos;
            line_neg <= next_line_neg;
            line_oe <= drv_en;
        end
    end
    assign line_out_pos_ch0_out = line_pos[LG_BIT_TX_CH0];
    assign line_out_neg_ch0_out = line_neg[LG_BIT_TX_CH0];
    assign line_out_pos_ch0_oe_out = line_oe[LG_BIT_TX_CH0];
    assign line_out_neg_ch0_oe_out = line_oe[LG_BIT_TX_CH0];
    assign line_out_pos_ch1_out = line_pos[LG_BIT_TX_CH1];
    assign line_out_neg_ch1_out = line_neg[LG_BIT_TX_CH1];
    assign line_out_pos_ch1_oe_out = line_oe[LG_BIT_TX_CH1];
    assign line_out_neg_ch1_oe_out = line_oe[LG_BIT_TX_CH1];
    // ------------------------------------------------------------
    // interrupt gate
    // ------------------------------------------------------------
    logic [2:0] ch_event;
    logic irq_req;
    logic next_irq_req;
    genvar c;
    generate
        for (c = 0; c < LG_NUM_CH; c++) begin : g_ch
            assign ch_event[c] = |(irq_src_pending_in[c*LG_SRC_PER_CH +: LG_SRC_PER_CH]
                                 & irq_src_enable_in[c*LG_SRC_PER_CH +: LG_SRC_PER_CH]);
        end
    endgenerate
    always_comb begin
        next_irq_req = |(ch_event & irq_en);
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= next_irq_req;
        end
    end
    assign irq_req_out = irq_req;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_ch1_enabled;
        tx_on[1] && pin_s2[1];
    endsequence
    sequence s_ch0_enabled;
        tx_on[0] && pin_s2[0];
    endsequence
    AST_CH1_DRIVE: assert property (
        s_ch1_enabled |=> line_out_pos_ch1_oe_out
            && line_out_pos_ch1_out == $past(tx_pos_ch1_in)
    ) else $error("ch1 not driving");
    AST_CH1_NEG_DATA: assert property (
        s_ch1_enabled |=> line_out_neg_ch1_oe_out
            && line_out_neg_ch1_out == $past(tx_neg_ch1_in)
    ) else $error("ch1 negative rail wrong");
    AST_CH1_OFF: assert property (
        !tx_on[1] |=> !line_out_pos_ch1_oe_out && !line_out_neg_ch1_oe_out
    ) else $error("ch1 not tri-stated");
    AST_CH1_IDLE_LOW: assert property (
        !tx_on[1] |=> !line_out_pos_ch1_out && !line_out_neg_ch1_out
    ) else $error("ch1 data while off");
    AST_CH0_DRIVE: assert property (
        s_ch0_enabled |=> line_out_neg_ch0_oe_out
            && line_out_neg_ch0_out == $past(tx_neg_ch0_in)
    ) else $error("ch0 not driving");
    AST_CH0_POS_DATA: assert property (
        s_ch0_enabled |=> line_out_pos_ch0_oe_out
            && line_out_pos_ch0_out == $past(tx_pos_ch0_in)
    ) else $error("ch0 positive rail wrong");
    AST_CH0_OFF: assert property (
        !tx_on[0] |=> !line_out_pos_ch0_oe_out && !line_out_neg_ch0_oe_out
    ) else $error("ch0 not tri-stated");
    AST_CH0_IDLE_LOW: assert property (
        !tx_on[0] |=> !line_out_pos_ch0_out && !line_out_neg_ch0_out
    ) else $error("ch0 data while off");
    AST_CH0_PIN: assert property (
        $fell(pin_s2[0]) |=> !line_out_pos_ch0_oe_out && !line_out_neg_ch0_oe_out
    ) else $error("ch0 pin ignored");
    AST_CH1_PIN: assert property (
        !tx_drive_pin_ch1_in [*3] |=> !line_out_neg_ch1_oe_out
    ) else $error("ch1 pin ignored");
    // ------------------------------------------------------------
    // interrupt gate assertions
    // ------------------------------------------------------------
    sequence s_irq_en_write;
        bus.wr_stb && hit(bus.addr, LG_OFF_BLOCK_IRQ_ENABLE);
    endsequence
    sequence s_irq_en_read;
        bus.rd_stb && hit(bus.addr, LG_OFF_BLOCK_IRQ_ENABLE);
    endsequence
    AST_IRQ_EN_WRITE: assert property (
        s_irq_en_write |=> irq_en == $past(bus.wdata[2:0])
            && (!hit(bus.addr, LG_OFF_BLOCK_IRQ_ENABLE) || bus.rdata[7:3] == 5'h00)
    ) else $error("enable write lost");
    AST_IRQ_EN_READ: assert property (
        s_irq_en_read |-> bus.rdata == {5'h00, irq_en}
    ) else $error("enable read wrong");
    AST_IRQ_EN_HOLD: assert property (
        !(bus.wr_stb && hit(bus.addr, LG_OFF_BLOCK_IRQ_ENABLE)) |=> $stable(irq_en)
    ) else $error("enable changed without write");
    AST_IRQ_MASKED: assert property (
        irq_en == 3'h0 |=> !irq_req_out
    ) else $error("masked interrupt raised");
    generate
        for (c = 0; c < LG_NUM_CH; c++) begin : g_mask
            AST_CH_MASKED: assert property (
                (ch_event & ~(3'h1 << c)) == 3'h0 && !irq_en[c] |=> !irq_req_out
            ) else $error("channel mask ignored");
        end
    endgenerate
    AST_IRQ_SOURCE: assert property (
        irq_src_enable_in == 12'h000 |=> !irq_req_out
    ) else $error("unenabled source raised");
    AST_IRQ_PASS: assert property (
        (ch_event & irq_en) != 3'h0 |=> irq_req_out
    ) else $error("enabled event dropped");
    AST_IRQ_OR: assert property (
        1'b1 |=> irq_req_out == $past(|(ch_event & irq_en))
    ) else $error("request mismatch");
endmodule

// file: hdl/lg_pkg.sv
// constants for the line driver and interrupt gate register block
package lg_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] LG_OFF_LINE_SECTION_POWER = 7'h1e;
    localparam logic [6:0] LG_OFF_BLOCK_IRQ_ENABLE = 7'h20;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LG_BIT_TX_CH0 = 0;
    localparam int LG_BIT_TX_CH1 = 1;
    localparam int LG_NUM_CH = 3;
    localparam int LG_NUM_TX = 2;
    localparam int LG_SRC_PER_CH = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] LG_RST_TX_ON = 2'h0;
    localparam logic [2:0] LG_RST_IRQ_EN = 3'h0;
    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam logic [2:0] LG_ADDR_LAST = 3'h6;
    localparam logic [2:0] LG_DATA_LAST = 3'h7;
    typedef enum logic [1:0] {
        LG_SP_IDLE = 2'h0,
        LG_SP_ADDR = 2'h1,
        LG_SP_DATA = 2'h3,
        LG_SP_DONE = 2'h2
    } lg_sp_state_t;
endpackage

// file: hdl/lg_reg_if.sv
// register access carrier between serial port and register bank
`timescale 1ns/1ps
interface lg_reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport bank (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// file: hdl/lg_serial_port.sv
// serial microprocessor port slave, oversampled on the core clock
`timescale 1ns/1ps
module lg_serial_port
    import lg_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    lg_reg_if.port bus
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic sclk_s3;
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_s1 <= 3'h1;
            pin_s2 <= 3'h1;
            sclk_s3 <= 1'b0;
        end else begin
            pin_s1 <= {sdi_in, sclk_in, cs_n_in};
            pin_s2 <= pin_s1;
            sclk_s3 <= pin_s2[1];
        end
    end
    logic cs_act;
    logic rise;
    logic sdi;
    assign cs_act = !pin_s2[0];
    assign rise = pin_s2[1] && !sclk_s3;
    assign sdi = pin_s2[2];
    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    lg_sp_state_t state;
    lg_sp_state_t next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic rw;
    logic next_rw;
    logic [6:0] addr;
    logic [6:0] next_addr;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rw = rw;
        next_addr = addr;
        next_shreg = shreg;
        bus.wr_stb = 1'b0;
        bus.rd_stb = 1'b0;
        if (!cs_act) begin
            next_state = LG_SP_IDLE;
            next_bit_cnt = 3'h0;
        end else if (rise) begin
            unique case (state)
                LG_SP_IDLE: begin
                    next_rw = sdi;
                    next_bit_cnt = 3'h0;
                    next_state = LG_SP_ADDR;
                end
                LG_SP_ADDR: begin
                    next_addr = {addr[5:0], sdi};
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == LG_ADDR_LAST) begin
                        next_bit_cnt = 3'h0;
                        next_state = LG_SP_DATA;
                        bus.rd_stb = rw;
                        next_shreg = rw ? bus.rdata : 8'h00;
                    end
                end
                LG_SP_DATA: begin
                    next_shreg = {shreg[6:0], sdi};
                    next_bit_cnt = bit_cnt + 3'h1;
                    if (bit_cnt == LG_DATA_LAST) begin
                        bus.wr_stb = !rw;
                        next_state = LG_SP_DONE;
                    end
                end
                LG_SP_DONE: begin
                    next_state = LG_SP_DONE;
                end
            endcase
        end
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= LG_SP_IDLE;
            bit_cnt <= 3'h0;
            rw <= 1'b0;
            addr <= 7'h00;
            shreg <= 8'h00;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rw <= next_rw;
            addr <= next_addr;
            shreg <= next_shreg;
        end
    end
    assign bus.addr = (state == LG_SP_DATA) ? addr : {addr[5:0], sdi};
    assign bus.wdata = {shreg[6:0], sdi};
    assign sdo_out = shreg[7];
    assign sdo_oe_out = (state == LG_SP_DATA) && rw && cs_act;
endmodule

// file: test/lg_tx_irq_gate_tb_top.sv
// self-checking bench for the line driver and interrupt gate block
`timescale 1ns/1ps
module lg_tx_irq_gate_tb_top;
    import lg_pkg::*;
    logic core_clk_in;
    logic reset_n_in;
    logic cs_n_in;
    logic sclk_in;
    logic sdi_in;
    logic sdo_out;
    logic sdo_oe_out;
    logic [1:0] pin;
    logic [3:0] pulse;
    logic [3:0] lo;
    logic [3:0] lo_oe;
    logic [11:0] pend;
    logic [11:0] srcen;
    logic irq_req_out;
    int num_errors;
    int compares;
    int model_tx;
    int model_irq;
    int cycles;

    // ------------------------------------------------------------
    // design and clock
    // ------------------------------------------------------------
    lg_tx_irq_gate u_lg_tx_irq_gate (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .cs_n_in(cs_n_in),
        .sclk_in(sclk_in),
        .sdi_in(sdi_in),
        .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out),
        .tx_drive_pin_ch0_in(pin[0]),
        .tx_drive_pin_ch1_in(pin[1]),
        .tx_pos_ch0_in(pulse[0]),
        .tx_neg_ch0_in(pulse[1]),
        .tx_pos_ch1_in(pulse[2]),
        .tx_neg_ch1_in(pulse[3]),
        .line_out_pos_ch0_out(lo[0]),
        .line_out_pos_ch0_oe_out(lo_oe[0]),
        .line_out_neg_ch0_out(lo[1]),
        .line_out_neg_ch0_oe_out(lo_oe[1]),
        .line_out_pos_ch1_out(lo[2]),
        .line_out_pos_ch1_oe_out(lo_oe[2]),
        .line_out_neg_ch1_out(lo[3]),
        .line_out_neg_ch1_oe_out(lo_oe[3]),
        .irq_src_pending_in(pend),
        .irq_src_enable_in(srcen),
        .irq_req_out(irq_req_out)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    initial begin
        cycles = 0;
        forever begin
            @(posedge core_clk_in);
            cycles++;
            if (cycles == 30000) begin
                num_errors++;
                wrap_up();
            end
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [15:0] bits;
        bits = {rd, a, d};
        q = 8'h00;
        cs_n_in = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (rd && i >= 8) begin
                q[15 - i] = sdo_out;
                check({7'h00, sdo_oe_out}, 8'h01);
            end
            sclk_in = 1'b0;
            sdi_in = bits[15 - i];
            step(5);
            sclk_in = 1'b1;
            step(5);
        end
        sclk_in = 1'b0;
        step(5);
        cs_n_in = 1'b1;
        step(5);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        frame(1'b0, a, d, q);
        if (a == LG_OFF_BLOCK_IRQ_ENABLE) model_irq = int'(d) & 7;
        if (a == LG_OFF_LINE_SECTION_POWER) model_tx = int'(d) & 3;
    endtask

    task automatic rd_chk(input logic [6:0] a);
        logic [7:0] q;
        int exp;
        frame(1'b1, a, 8'h00, q);
        exp = 0;
        if (a == LG_OFF_BLOCK_IRQ_ENABLE) exp = model_irq;
        if (a == LG_OFF_LINE_SECTION_POWER) exp = model_tx;
        check(q, exp[7:0]);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int exp;
        int en;
        logic [15:0] abort_bits;
        void'($urandom(95463));
        {reset_n_in, cs_n_in, sclk_in, sdi_in} = 4'h4;
        {pin, pulse, pend, srcen} = '0;
        model_tx = 0;
        model_irq = 0;
        step(2);
        reset_n_in = 1'b1;
        check({irq_req_out, lo_oe, 3'h0}, 8'h00);
        step(2);
        rd_chk(LG_OFF_BLOCK_IRQ_ENABLE);
        rd_chk(LG_OFF_LINE_SECTION_POWER);
        wr(7'h05, 8'hff);
        rd_chk(7'h05);
        for (int k = 0; k < 16; k++) begin
            wr(LG_OFF_LINE_SECTION_POWER, {6'($urandom), 2'(k)});
            rd_chk(LG_OFF_LINE_SECTION_POWER);
            pin = 2'(k >> 2);
            step(5);
            pulse = 4'($urandom);
            step(2);
            en = 0;
            for (int c = 0; c < 2; c++) begin
                if (model_tx[c] && pin[c]) en |= 3 << (2 * c);
            end
            check({4'h0, lo_oe}, 8'(en));
            check({4'h0, lo}, 8'(en & int'(pulse)));
        end
        for (int k = 0; k < 16; k++) begin
            wr(LG_OFF_BLOCK_IRQ_ENABLE, {5'($urandom), 3'(k)});
            rd_chk(LG_OFF_BLOCK_IRQ_ENABLE);
            for (int j = 0; j < 4; j++) begin
                pend = (j == 0) ? 12'hfff : 12'($urandom);
                srcen = (j == 0) ? 12'hfff : 12'($urandom);
                step(3);
                exp = 0;
                for (int c = 0; c < LG_NUM_CH; c++) begin
                    if (model_irq[c] && (pend[4 * c +: 4] & srcen[4 * c +: 4]) != 0) exp = 1;
                end
                check({7'h00, irq_req_out}, 8'(exp));
            end
        end
        abort_bits = {1'b0, LG_OFF_BLOCK_IRQ_ENABLE, ~8'(model_irq)};
        cs_n_in = 1'b0;
        for (int i = 0; i < 15; i++) begin
            sclk_in = 1'b0;
            sdi_in = abort_bits[15 - i];
            step(5);
            sclk_in = 1'b1;
            step(5);
        end
        sclk_in = 1'b0;
        step(5);
        cs_n_in = 1'b1;
        step(5);
        rd_chk(LG_OFF_BLOCK_IRQ_ENABLE);
        reset_n_in = 1'b0;
        step(2);
        reset_n_in = 1'b1;
        model_tx = 0;
        model_irq = 0;
        check({irq_req_out, lo_oe, 3'h0}, 8'h00);
        step(2);
        rd_chk(LG_OFF_BLOCK_IRQ_ENABLE);
        rd_chk(LG_OFF_LINE_SECTION_POWER);
        wrap_up();
    end
endmodule
